// [inc/rst_pkg.sv]
// Constants, layouts and types for the relay self-test supervisor
package rst_pkg;

	// ------------------------------------------------------------
	// Clock and times
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 64'h0000_0000_0EE6_B280;
	localparam longint unsigned OFFSET_PERIOD_S = 64'h0000_0000_0000_000A;
	localparam longint unsigned RAM_PERIOD_S = 64'h0000_0000_0000_003C;
	localparam longint unsigned CHECKSUM_PERIOD_S = 64'h0000_0000_0000_000A;
	localparam longint unsigned ALARM_PULSE_S = 64'h0000_0000_0000_0005;
	localparam longint unsigned ZC_TIMEOUT_MS = 64'h0000_0000_0000_0064;
	localparam longint unsigned MS_PER_S = 64'h0000_0000_0000_03E8;
	localparam longint unsigned OFFSET_PERIOD_CYC = OFFSET_PERIOD_S * CLK_HZ;
	localparam longint unsigned RAM_PERIOD_CYC = RAM_PERIOD_S * CLK_HZ;
	localparam longint unsigned CHECKSUM_PERIOD_CYC = CHECKSUM_PERIOD_S * CLK_HZ;
	localparam longint unsigned ALARM_PULSE_CYC = ALARM_PULSE_S * CLK_HZ;
	localparam longint unsigned ZC_TIMEOUT_CYC = ZC_TIMEOUT_MS * CLK_HZ / MS_PER_S;
	localparam int CNT_W = 36;

	// ------------------------------------------------------------
	// Periodic tests and failure bits
	// ------------------------------------------------------------
	localparam int N_TESTS = 5;
	localparam int T_OFFSET = 0;
	localparam int T_RAM = 1;
	localparam int T_ROM = 2;
	localparam int T_ACTIVE = 3;
	localparam int T_NV = 4;
	localparam int N_FAIL = 8;
	localparam int FB_RAM = 0;
	localparam int FB_ROM = 1;
	localparam int FB_ADC = 2;
	localparam int FB_FREQUENCY_TRACKING_CHECK = 3;
	localparam int FB_ACTIVE = 4;
	localparam int FB_NV = 5;
	localparam int FB_XTAL = 6;
	localparam int FB_PROC = 7;
	localparam logic [7:0] REPORT_MASK = 8'h3F;
	localparam int N_CHAN = 5;
	localparam int MV_W = 8;
	localparam logic [7:0] OFFSET_LIMIT_MV = 8'h32;
	localparam logic [7:0] CONV_PER_QUARTER = 8'h10;

	// ------------------------------------------------------------
	// Elements, contacts, recorder
	// ------------------------------------------------------------
	localparam int N_ELEM = 16;
	localparam int ELEM_SEL_W = 4;
	localparam int ROW_W = 8;
	localparam int UV_BIT = 0;
	localparam int N_CONTACTS = 5;
	localparam int CSEL_W = 5;
	localparam int N_LISTS = 3;
	localparam int TIME_W = 32;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_UV_PICKUP = 4'h1;
	localparam logic [3:0] ADDR_CONTACT = 4'h2;
	localparam logic [3:0] ADDR_LIST0 = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam int CTRL_VOLT_EN = 0;
	localparam int ST_WARN = 8;
	localparam int ST_DISABLED = 9;
	localparam int ST_ALARM = 10;
	localparam logic [15:0] UV_PICKUP_RST = 16'h0000;
	localparam int REPORT_W = 9;

	typedef enum logic [1:0] {ALM_IDLE, ALM_PULSE, ALM_LATCHED} rst_alarm_e;

	// Failure bit driven by each periodic test other than the offset check
	function automatic int test_fail_bit(input int t);
		case (t)
			T_RAM: test_fail_bit = FB_RAM;
			T_ROM: test_fail_bit = FB_ROM;
			T_ACTIVE: test_fail_bit = FB_ACTIVE;
			default: test_fail_bit = FB_NV;
		endcase
	endfunction : test_fail_bit

endpackage : rst_pkg

// [sim/rst_far_side.sv]
// Far-side model: test engines, sampling chain, zero crossings
`timescale 1ns/10ps
module rst_far_side (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [4:0] start_i,
	input wire logic [4:0] fail_cmd_i,
	input wire logic slow_i,
	input wire logic adc_on_i,
	input wire logic zc_on_i,
	output logic [4:0] done_o,
	output logic [4:0] fail_o,
	output logic adc_conv_o,
	output logic quarter_o,
	output logic zero_cross_o
);
	logic [2:0] wait_reg [5];
	logic [4:0] ph_reg;
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < 5; i++) begin
			if (reset_i) wait_reg[i] <= 3'h0;
			else if (start_i[i]) wait_reg[i] <= slow_i ? 3'h6 : 3'h1;
			else if (wait_reg[i] != 3'h0) wait_reg[i] <= wait_reg[i] - 3'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			done_o[i] = (wait_reg[i] == 3'h1);
			fail_o[i] = done_o[i] ? fail_cmd_i[i] : ~fail_cmd_i[i];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		ph_reg <= (reset_i || ph_reg == 5'h13) ? 5'h00 : ph_reg + 5'h01;
	end
	assign quarter_o = !reset_i && ph_reg == 5'h13;
	assign adc_conv_o = adc_on_i && ph_reg != 5'h13;
	assign zero_cross_o = zc_on_i && ph_reg[3:0] == 4'h9;
endmodule : rst_far_side

// [sim/tb.sv]
// Self-checking bench for the self-test supervisor
`timescale 1ns/10ps
module tb;
	import rst_pkg::*;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, qv = 1'b0;
	logic slow = 1'b0, adc_on = 1'b1, zc_on = 1'b1, seen;
	logic [3:0] addr = 4'h0, qbit = 4'h0, fault = 4'h0, evb;
	logic [31:0] wdata = 32'h0000_0000, rdata, evt, t0;
	logic [4:0] start, done, fail, ct, fail_cmd = 5'h00;
	logic [39:0] offs = 40'h00_0000_0000;
	logic [15:0] va = 16'hFFFF, elems = 16'h0000;
	logic adc, quarter, zc, qv_o, alm, en, led, halt, rv, evv, evl;
	logic [7:0] row;
	logic [8:0] code;
	int err_total = 0, compares = 0, cyc = 0, n_ram = 0, n_rom = 0;
	int fb[6] = '{FB_RAM, FB_ROM, FB_ACTIVE, FB_NV, FB_ADC, FB_FREQUENCY_TRACKING_CHECK};
	always #2 ref_clk_i = ~ref_clk_i;
	rst_supervisor #(.OFFSET_CYC(100), .RAM_CYC(600), .CHECKSUM_CYC(100), .PULSE_CYC(50), .ZC_CYC(40))
	i_rst_supervisor (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .test_start_o(start), .test_done_i(done),
		.test_fail_i(fail), .offset_mv_i(offs), .adc_conv_i(adc), .quarter_cycle_i(quarter),
		.zero_cross_i(zc), .xtal_fault_i(fault[0]), .instr_invalid_i(fault[1]),
		.mem_access_invalid_i(fault[2]), .irq_invalid_i(fault[3]), .va_mag_i(va),
		.element_bits_i(elems), .query_valid_i(qv), .query_bit_i(qbit), .query_valid_o(qv_o),
		.query_row_o(row), .contact_o(ct), .protection_enable_o(en), .enabled_led_o(led),
		.alarm_energize_o(alm), .proc_halt_o(halt), .report_valid_o(rv), .report_code_o(code),
		.event_valid_o(evv), .event_bit_o(evb), .event_level_o(evl), .event_time_o(evt));
	rst_far_side i_rst_far_side (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start),
		.fail_cmd_i(fail_cmd), .slow_i(slow), .adc_on_i(adc_on), .zc_on_i(zc_on), .done_o(done),
		.fail_o(fail), .adc_conv_o(adc), .quarter_o(quarter), .zero_cross_o(zc));
	task automatic complete_run;
		if (err_total == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic do_reset;
		reset_i <= 1'b1;
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 1'b0;
	endtask : do_reset
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd_chk
	task automatic qry(input logic [3:0] b, input logic [7:0] e);
		@(posedge ref_clk_i);
		qbit <= b;
		qv <= 1'b1;
		@(posedge ref_clk_i);
		qv <= 1'b0;
		#1 chk("query_row", e, row);
		chk("query_valid", 1, qv_o);
	endtask : qry
	task automatic ev_chk(input logic lvl);
		for (int i = 0; i < 10 && evv !== 1'b1; i++) tick();
		chk("event", {1'b1, 4'h0, lvl}, {evv, evb, evl});
	endtask : ev_chk
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc > 30000) begin
			err_total++;
			complete_run();
		end
	end
	always @(posedge ref_clk_i) begin
		n_ram <= reset_i ? 0 : n_ram + start[1];
		n_rom <= reset_i ? 0 : n_rom + start[2];
	end
	initial begin
		do_reset();
		repeat (650) tick();
		chk("ram_runs", 1, n_ram);
		chk("rom_runs", 6, n_rom);
		rd_chk(ADDR_STATUS, 32'h0000_0000);
		rd_chk(4'h7, 32'h0000_0000);
		wr_reg(ADDR_LIST0, 32'h0000_0001);
		wr_reg(ADDR_UV_PICKUP, 32'h0000_0100);
		wr_reg(ADDR_CONTACT, 32'h0008_0000);
		va <= 16'h00FF;
		repeat (4) tick();
		chk("contact_off", 5'h00, ct);
		wr_reg(ADDR_CTRL, 32'h0000_0001);
		ev_chk(1'b1);
		t0 = evt;
		tick();
		chk("contact_on", 5'h08, ct);
		@(posedge ref_clk_i);
		elems <= 16'hA5C2;
		qry(4'h9, 8'hA5);
		qry(4'h3, 8'hC3);
		@(posedge ref_clk_i);
		va <= 16'h0100;
		ev_chk(1'b0);
		chk("ev_time", 1, evt > t0);
		@(posedge ref_clk_i);
		offs <= 40'h33_0000_0000;
		for (int i = 0; i < 150 && rv !== 1'b1; i++) tick();
		chk("warn_code", 9'h100, code);
		@(posedge ref_clk_i);
		offs <= 40'h32_3232_3232;
		tick();
		chk("warn_state", 2'b10, {en, alm});
		repeat (44) tick();
		chk("pulse_mid", 0, alm);
		repeat (12) tick();
		chk("pulse_end", 1, alm);
		for (int k = 0; k < 6; k++) begin
			@(posedge ref_clk_i);
			fail_cmd <= (k < 4) ? 5'h02 << k : 5'h00;
			adc_on <= (k != 4);
			zc_on <= (k != 5);
			slow <= k[0];
			do_reset();
			va <= 16'h0000;
			wr_reg(ADDR_CTRL, 32'h0000_0001);
			wr_reg(ADDR_UV_PICKUP, 32'h0000_0100);
			wr_reg(ADDR_CONTACT, 32'h0008_0000);
			repeat (3) tick();
			chk("contact_up", 5'h08, ct);
			for (int i = 0; i < 800 && rv !== 1'b1; i++) tick();
			chk("fail_code", 9'h001 << fb[k], code);
			tick();
			chk("disabled", 8'h00, {en, led, alm, ct});
			repeat (80) tick();
			chk("latched", 0, alm);
			rd_chk(ADDR_STATUS, 32'h0000_0600 | (32'h0000_0001 << fb[k]));
		end
		@(posedge ref_clk_i);
		fail_cmd <= 5'h00;
		adc_on <= 1'b1;
		zc_on <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			do_reset();
			repeat (3) @(posedge ref_clk_i);
			fault <= 4'h1 << j;
			seen = 1'b0;
			repeat (6) begin
				tick();
				seen = seen | rv;
			end
			chk("halt", 4'h8, {halt, en, alm, seen});
			@(posedge ref_clk_i);
			fault <= 4'h0;
		end
		complete_run();
	end
endmodule : tb

// [verilog/rst_interval_timer.sv]
// Free-running interval timer issuing a one-cycle due pulse
`timescale 1ns/10ps
module rst_interval_timer #(
	parameter longint unsigned PERIOD = 64'h0000_0000_0000_000A
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	output logic due_o
);
	import rst_pkg::*;

	logic [CNT_W-1:0] count_reg;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 64'h0000_0000_0000_0001);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			count_reg <= '0;
			due_o <= 1'b0;
		end else if (enable_i) begin
			due_o <= (count_reg == LAST);
			if (count_reg == LAST) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + CNT_W'(1);
			end
		end else begin
			due_o <= 1'b0;
		end
	end

endmodule : rst_interval_timer

// [verilog/rst_supervisor.sv]
// Relay self-test supervisor: schedules checks, classes results, drives alarm and outputs
//
// What this block does
// - Any failure disables protection, drops all output contacts and the enabled lamp.
// - Alarm is shown by de-energizing the normally closed alarm contact.
// - Alarm is either one five-second pulse or latched, chosen per test.
// - Every warning and reportable failure sends an unsolicited status report.
// - Input dc offsets checked every 10 s; above 50 mV warns and pulses alarm.
// - Working memory test every 60 s; mismatch fails, latches alarm.
// - Program memory checksum every 10 s; mismatch fails, latches alarm.
// - Too few conversions in a quarter cycle fails, latches alarm.
// - Missing zero crossings for frequency tracking fails, latches alarm.
// - Active settings checksum every 10 s; mismatch fails, latches alarm.
// - Stored settings checksum every 10 s; mismatch fails, latches alarm.
// - Crystal or processor fault halts processor, latches alarm, not reported.
// - Every instruction, memory access and interrupt is checked for validity.
// - Status query returns the whole row holding the named element bit.
// - Any element bit may be assigned to drive one of five contacts.
// - Listed elements record a time-stamped entry on each rise and fall.
// - Phase-A undervoltage asserts while voltage is below its pickup.
// - Enable-governed elements stay inactive unless their enable is set.
`timescale 1ns/10ps
module rst_supervisor #(
	parameter longint unsigned OFFSET_CYC = rst_pkg::OFFSET_PERIOD_CYC,
	parameter longint unsigned RAM_CYC = rst_pkg::RAM_PERIOD_CYC,
	parameter longint unsigned CHECKSUM_CYC = rst_pkg::CHECKSUM_PERIOD_CYC,
	parameter longint unsigned PULSE_CYC = rst_pkg::ALARM_PULSE_CYC,
	parameter longint unsigned ZC_CYC = rst_pkg::ZC_TIMEOUT_CYC
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	output logic [rst_pkg::N_TESTS-1:0] test_start_o,
	input wire logic [rst_pkg::N_TESTS-1:0] test_done_i,
	input wire logic [rst_pkg::N_TESTS-1:0] test_fail_i,
	input wire logic [rst_pkg::N_CHAN*rst_pkg::MV_W-1:0] offset_mv_i,
	input wire logic adc_conv_i,
	input wire logic quarter_cycle_i,
	input wire logic zero_cross_i,
	input wire logic xtal_fault_i,
	input wire logic instr_invalid_i,
	input wire logic mem_access_invalid_i,
	input wire logic irq_invalid_i,
	input wire logic [15:0] va_mag_i,
	input wire logic [rst_pkg::N_ELEM-1:0] element_bits_i,
	input wire logic query_valid_i,
	input wire logic [rst_pkg::ELEM_SEL_W-1:0] query_bit_i,
	output logic query_valid_o,
	output logic [rst_pkg::ROW_W-1:0] query_row_o,
	output logic [rst_pkg::N_CONTACTS-1:0] contact_o,
	output logic protection_enable_o,
	output logic enabled_led_o,
	output logic alarm_energize_o,
	output logic proc_halt_o,
	output logic report_valid_o,
	output logic [rst_pkg::REPORT_W-1:0] report_code_o,
	output logic event_valid_o,
	output logic [rst_pkg::ELEM_SEL_W-1:0] event_bit_o,
	output logic event_level_o,
	output logic [rst_pkg::TIME_W-1:0] event_time_o
);
	import rst_pkg::*;

	// Row of a given element bit
	function automatic logic [ROW_W-1:0] elem_row(input logic [N_ELEM-1:0] e, input logic [ELEM_SEL_W-1:0] b);
		elem_row = e[(int'(b) / ROW_W) * ROW_W +: ROW_W];
	endfunction : elem_row

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 64'h0000_0000_0000_0001);
	localparam logic [CNT_W-1:0] ZC_LAST = CNT_W'(ZC_CYC - 64'h0000_0000_0000_0001);

	logic ctrl_volt_en_reg;
	logic [15:0] uv_pickup_reg;
	logic [N_CONTACTS*CSEL_W-1:0] contact_sel_reg;
	logic [N_ELEM-1:0] list_reg [N_LISTS];
	logic [N_FAIL-1:0] fail_reg;
	logic [N_FAIL-1:0] fail_next;
	logic warn_reg;
	logic warn_evt;
	logic [N_CHAN-1:0] chan_over;
	logic [N_TESTS-1:0] due;
	logic [7:0] conv_count_reg;
	logic adc_armed_reg;
	logic [CNT_W-1:0] zc_count_reg;
	logic [CNT_W-1:0] pulse_count_reg;
	rst_alarm_e alarm_reg;
	rst_alarm_e alarm_next;
	logic uv_reg;
	logic [N_ELEM-1:0] elem;
	logic [N_ELEM-1:0] watched;
	logic [N_ELEM-1:0] prev_reg;
	logic [N_ELEM-1:0] prev_next;
	logic chg_any;
	logic [ELEM_SEL_W-1:0] chg_bit;
	logic [TIME_W-1:0] time_reg;
	logic proc_fault;
	logic adc_short;
	logic zc_lost;

	// ------------------------------------------------------------
	// Periodic schedulers
	// ------------------------------------------------------------
	genvar gt;
	generate
		for (gt = 0; gt < N_TESTS; gt++) begin : g_timer
			localparam longint unsigned PER = (gt == T_OFFSET) ? OFFSET_CYC :
				(gt == T_RAM) ? RAM_CYC : CHECKSUM_CYC;
			rst_interval_timer #(.PERIOD(PER)) u_timer (
				.ref_clk_i(ref_clk_i),
				.reset_i(reset_i),
				.enable_i(!proc_halt_o),
				.due_o(due[gt])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			test_start_o <= '0;
		end else begin
			test_start_o <= due;
		end
	end

	// ------------------------------------------------------------
	// Offset warning
	// ------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < N_CHAN; gc++) begin : g_chan
			assign chan_over[gc] = offset_mv_i[gc*MV_W +: MV_W] > OFFSET_LIMIT_MV;
		end
	endgenerate
	assign warn_evt = test_done_i[T_OFFSET] && (|chan_over);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			warn_reg <= 1'b0;
		end else if (test_done_i[T_OFFSET]) begin
			warn_reg <= |chan_over;
		end
	end

	// ------------------------------------------------------------
	// Conversion count and zero crossing watch
	// ------------------------------------------------------------
	// Conversions per quarter cycle
	assign adc_short = quarter_cycle_i && adc_armed_reg && (conv_count_reg < CONV_PER_QUARTER);
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			conv_count_reg <= '0;
			adc_armed_reg <= 1'b0;
		end else if (quarter_cycle_i) begin
			conv_count_reg <= adc_conv_i ? 8'h01 : 8'h00;
			adc_armed_reg <= 1'b1;
		end else if (adc_conv_i && conv_count_reg != 8'hFF) begin
			conv_count_reg <= conv_count_reg + 8'h01;
		end
	end

	assign zc_lost = !zero_cross_i && (zc_count_reg == ZC_LAST);
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || zero_cross_i) begin
			zc_count_reg <= '0;
		end else if (zc_count_reg != ZC_LAST) begin
			zc_count_reg <= zc_count_reg + CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Failure collection
	// ------------------------------------------------------------
	// Instruction, access and interrupt checks
	assign proc_fault = instr_invalid_i || mem_access_invalid_i || irq_invalid_i;

	always_comb begin
		fail_next = fail_reg;
		for (int t = T_RAM; t < N_TESTS; t++) begin
			if (test_done_i[t] && test_fail_i[t]) begin
				fail_next[test_fail_bit(t)] = 1'b1;
			end
		end
		if (adc_short) begin
			fail_next[FB_ADC] = 1'b1;
		end
		if (zc_lost) begin
			fail_next[FB_FREQUENCY_TRACKING_CHECK] = 1'b1;
		end
		if (xtal_fault_i) begin
			fail_next[FB_XTAL] = 1'b1;
		end
		if (proc_fault) begin
			fail_next[FB_PROC] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fail_reg <= '0;
		end else begin
			fail_reg <= fail_next;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			proc_halt_o <= 1'b0;
		end else if (xtal_fault_i || proc_fault) begin
			proc_halt_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Status report
	// ------------------------------------------------------------
	// Unsolicited reports, monitor faults excluded
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			report_valid_o <= 1'b0;
			report_code_o <= '0;
		end else begin
			report_valid_o <= warn_evt || (|(fail_next & ~fail_reg & REPORT_MASK));
			report_code_o <= {warn_evt, fail_next & REPORT_MASK};
		end
	end

	// ------------------------------------------------------------
	// Alarm contact
	// ------------------------------------------------------------
	always_comb begin
		alarm_next = alarm_reg;
		case (alarm_reg)
			ALM_LATCHED: alarm_next = ALM_LATCHED;
			ALM_PULSE: begin
				if (pulse_count_reg == PULSE_LAST && !warn_evt) begin
					alarm_next = ALM_IDLE;
				end
			end
			ALM_IDLE: begin
				if (warn_evt) begin
					alarm_next = ALM_PULSE;
				end
			end
			default: alarm_next = ALM_LATCHED;
		endcase
		if (|fail_next) begin
			alarm_next = ALM_LATCHED;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			alarm_reg <= ALM_IDLE;
			pulse_count_reg <= '0;
		end else begin
			alarm_reg <= alarm_next;
			if (warn_evt || alarm_reg != ALM_PULSE) begin
				pulse_count_reg <= '0;
			end else begin
				pulse_count_reg <= pulse_count_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			alarm_energize_o <= 1'b1;
		end else begin
			alarm_energize_o <= (alarm_next == ALM_IDLE);
		end
	end

	// ------------------------------------------------------------
	// Elements
	// ------------------------------------------------------------
	// Undervoltage with enable
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			uv_reg <= 1'b0;
		end else begin
			uv_reg <= ctrl_volt_en_reg && (va_mag_i < uv_pickup_reg);
		end
	end

	always_comb begin
		elem = element_bits_i;
		elem[UV_BIT] = uv_reg;
		if (|fail_reg) begin
			elem = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			query_valid_o <= 1'b0;
			query_row_o <= '0;
		end else begin
			query_valid_o <= query_valid_i;
			query_row_o <= query_valid_i ? elem_row(elem, query_bit_i) : '0;
		end
	end

	// ------------------------------------------------------------
	// Output contacts and protection
	// ------------------------------------------------------------
	genvar gk;
	generate
		for (gk = 0; gk < N_CONTACTS; gk++) begin : g_contact
			always_ff @(posedge ref_clk_i) begin
				if (reset_i) begin
					contact_o[gk] <= 1'b0;
				end else begin
					contact_o[gk] <= !(|fail_next) && contact_sel_reg[gk*CSEL_W + ELEM_SEL_W] &&
						elem[contact_sel_reg[gk*CSEL_W +: ELEM_SEL_W]];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			protection_enable_o <= 1'b0;
			enabled_led_o <= 1'b0;
		end else begin
			protection_enable_o <= !(|fail_next);
			enabled_led_o <= !(|fail_next);
		end
	end

	// ------------------------------------------------------------
	// Event recorder
	// ------------------------------------------------------------
	always_comb begin
		watched = '0;
		for (int l = 0; l < N_LISTS; l++) begin
			watched = watched | list_reg[l];
		end
		chg_any = 1'b0;
		chg_bit = '0;
		prev_next = (elem & ~watched) | (prev_reg & watched);
		for (int b = N_ELEM - 1; b >= 0; b--) begin
			if (watched[b] && (elem[b] != prev_reg[b])) begin
				chg_any = 1'b1;
				chg_bit = ELEM_SEL_W'(b);
			end
		end
		if (chg_any) begin
			prev_next[chg_bit] = elem[chg_bit];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prev_reg <= '0;
			time_reg <= '0;
			event_valid_o <= 1'b0;
			event_bit_o <= '0;
			event_level_o <= 1'b0;
			event_time_o <= '0;
		end else begin
			prev_reg <= prev_next;
			time_reg <= time_reg + TIME_W'(1);
			event_valid_o <= chg_any;
			if (chg_any) begin
				event_bit_o <= chg_bit;
				event_level_o <= elem[chg_bit];
				event_time_o <= time_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_volt_en_reg <= 1'b0;
			uv_pickup_reg <= UV_PICKUP_RST;
			contact_sel_reg <= '0;
			for (int l = 0; l < N_LISTS; l++) begin
				list_reg[l] <= '0;
			end
		end else if (reg_write_i) begin
			case (reg_addr_i)
				ADDR_CTRL: ctrl_volt_en_reg <= reg_wdata_i[CTRL_VOLT_EN];
				ADDR_UV_PICKUP: uv_pickup_reg <= reg_wdata_i[15:0];
				ADDR_CONTACT: contact_sel_reg <= reg_wdata_i[N_CONTACTS*CSEL_W-1:0];
				default: begin
					for (int l = 0; l < N_LISTS; l++) begin
						if (reg_addr_i == ADDR_LIST0 + 4'(l)) begin
							list_reg[l] <= reg_wdata_i[N_ELEM-1:0];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !reg_read_i) begin
			reg_rdata_o <= '0;
		end else begin
			case (reg_addr_i)
				ADDR_CTRL: reg_rdata_o <= 32'(ctrl_volt_en_reg);
				ADDR_UV_PICKUP: reg_rdata_o <= 32'(uv_pickup_reg);
				ADDR_CONTACT: reg_rdata_o <= 32'(contact_sel_reg);
				ADDR_LIST0: reg_rdata_o <= 32'(list_reg[0]);
				ADDR_LIST0 + 4'h1: reg_rdata_o <= 32'(list_reg[1]);
				ADDR_LIST0 + 4'h2: reg_rdata_o <= 32'(list_reg[2]);
				ADDR_STATUS: reg_rdata_o <= 32'({alarm_reg != ALM_IDLE, |fail_reg, warn_reg, fail_reg});
				default: reg_rdata_o <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_disable;
		@(posedge ref_clk_i) disable iff (reset_i)
		(|fail_reg) |=> !protection_enable_o && !enabled_led_o && contact_o == '0;
	endproperty
	a_disable: assert property (p_disable) else $error("protection still on after failure");

	property p_alarm_contact;
		@(posedge ref_clk_i) disable iff (reset_i)
		(|fail_reg) |=> !alarm_energize_o;
	endproperty
	a_alarm_contact: assert property (p_alarm_contact) else $error("alarm contact energized on failure");

	property p_pulse;
		@(posedge ref_clk_i) disable iff (reset_i)
		(warn_evt && alarm_reg == ALM_IDLE && fail_next == '0) |=> (alarm_reg == ALM_PULSE) && !alarm_energize_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("warning did not start pulse");

	property p_report;
		@(posedge ref_clk_i) disable iff (reset_i)
		warn_evt |=> report_valid_o && report_code_o[REPORT_W-1];
	endproperty
	a_report: assert property (p_report) else $error("warning not reported");

	property p_offset;
		@(posedge ref_clk_i) disable iff (reset_i)
		(test_done_i[T_OFFSET] && !(|chan_over) && fail_next == '0) |=> protection_enable_o;
	endproperty
	a_offset: assert property (p_offset) else $error("offset check disabled relay");

	property p_sticky;
		@(posedge ref_clk_i) disable iff (reset_i)
		(|fail_reg) |=> ((fail_reg & $past(fail_reg)) == $past(fail_reg)) && alarm_reg == ALM_LATCHED;
	endproperty
	a_sticky: assert property (p_sticky) else $error("failure or latch cleared");

	property p_halt_silent;
		@(posedge ref_clk_i) disable iff (reset_i)
		(proc_fault && !warn_evt && ((fail_next & ~fail_reg & REPORT_MASK) == '0)) |=>
			proc_halt_o && !report_valid_o;
	endproperty
	a_halt_silent: assert property (p_halt_silent) else $error("monitor fault reported or no halt");

	property p_uv_enable;
		@(posedge ref_clk_i) disable iff (reset_i)
		!ctrl_volt_en_reg |=> !uv_reg;
	endproperty
	a_uv_enable: assert property (p_uv_enable) else $error("undervoltage active while disabled");

	property p_event;
		@(posedge ref_clk_i) disable iff (reset_i)
		chg_any |=> event_valid_o && event_time_o == $past(time_reg) && event_bit_o == $past(chg_bit);
	endproperty
	a_event: assert property (p_event) else $error("element change not recorded");

endmodule : rst_supervisor
